// *** hw/iepb_regs.vh ***
`ifndef IEPB_REGS_VH
`define IEPB_REGS_VH

// Register byte addresses (one aligned word each)
`define IEPB_ADDR_FLAGS      8'h00
`define IEPB_ADDR_ENABLE     8'h04
`define IEPB_ADDR_PRIO0      8'h10
`define IEPB_ADDR_PRIO_LAST  8'h2C
`define IEPB_ADDR_EVT_STAT   8'h30
`define IEPB_ADDR_EVT_MASK   8'h34
`define IEPB_ADDR_PRESENT    8'h38

// Priority register layout, per byte lane
`define IEPB_PRIO_LSB        2
`define IEPB_PRIO_W          3
`define IEPB_SUB_LSB         0
`define IEPB_SUB_W           2
`define IEPB_LANE_MASK       32'h1F1F1F1F

// Reset values
`define IEPB_RST_WORD        32'h00000000

// Event status bit positions
`define IEPB_EVT_NEW_REQ     0
`define IEPB_EVT_BAD_ADDR    1
`define IEPB_EVT_W           2

`endif

// *** hw/iepb_bank.v ***
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`include "iepb_regs.vh"

// Overview of operation
// [R1] Enable bit per source gates its request
// [R2] Priority 1..7, seven highest, zero disables
// [R3] Subpriority 0..3 orders equal priorities
// [R4] Priority fields at bits 4-2,12-10,20-18,28-26
// [R5] Subpriority fields at bits 1-0,9-8,17-16,25-24
// [R6] Top three lane bits read zero
// [R7] All configuration clears at reset
// [R8] Flag set by source, software may write
// [R9] Highest priority then subpriority presented
module iepb_bank #(
  parameter NSRC = 32
) (
  // Clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  // Register port
  input  wire [7:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  // Source request pulses
  input  wire [31:0] i_src_req,
  // Request to processor core
  output reg         o_core_req,
  output reg  [4:0]  o_core_vec,
  output reg  [2:0]  o_core_prio,
  output reg  [1:0]  o_core_sub,
  // Block interrupt
  output wire        o_irq
);

  localparam NPRIO = NSRC / 4;

  reg  [31:0] flags_q;
  reg  [31:0] enable_q;
  reg  [31:0] prio_q [0:NPRIO-1];
  reg  [`IEPB_EVT_W-1:0] evt_stat_q;
  reg  [`IEPB_EVT_W-1:0] evt_mask_q;
  reg  [4:0]  last_vec_q;
  reg         last_req_q;

  wire        hit_prio;
  wire [7:0]  prio_off;
  wire [2:0]  prio_idx;
  wire        addr_ok;

  // Priority register decode
  assign prio_off = i_addr - `IEPB_ADDR_PRIO0;
  assign hit_prio = (i_addr >= `IEPB_ADDR_PRIO0) && (i_addr <= `IEPB_ADDR_PRIO_LAST)
                    && (i_addr[1:0] == 2'h0);
  assign prio_idx = prio_off[4:2];
  assign addr_ok  = hit_prio || (i_addr == `IEPB_ADDR_FLAGS) ||
                    (i_addr == `IEPB_ADDR_ENABLE) || (i_addr == `IEPB_ADDR_EVT_STAT) ||
                    (i_addr == `IEPB_ADDR_EVT_MASK) || (i_addr == `IEPB_ADDR_PRESENT);

  // Request flags: source set wins over software write
  // [R8] flag set and write
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_q <= `IEPB_RST_WORD;
    end else if (i_wr && i_addr == `IEPB_ADDR_FLAGS) begin
      flags_q <= i_wdata | i_src_req;
    end else begin
      flags_q <= flags_q | i_src_req;
    end
  end

  // Enable mask, fully read/write
  // [R1] enable register
  // [R7] reset clear
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_q <= `IEPB_RST_WORD;
    end else if (i_wr && i_addr == `IEPB_ADDR_ENABLE) begin
      enable_q <= i_wdata;
    end
  end

  // Priority registers; unimplemented lane bits never stored
  // [R6] masked write
  // [R7] reset clear
  genvar g;
  generate
    for (g = 0; g < NPRIO; g = g + 1) begin : g_prio
      always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          prio_q[g] <= `IEPB_RST_WORD;
        end else if (i_wr && hit_prio && prio_idx == g) begin
          prio_q[g] <= i_wdata & `IEPB_LANE_MASK;
        end
      end
    end
  endgenerate

  // Arbitration over all sources, combinational
  reg        best_req;
  reg [4:0]  best_vec;
  reg [2:0]  best_prio;
  reg [1:0]  best_sub;
  reg [31:0] word;
  reg [7:0]  lane;
  reg [2:0]  p;
  reg [1:0]  s;
  integer    k;
  always @* begin
    best_req  = 1'b0;
    best_vec  = 5'h00;
    best_prio = 3'h0;
    best_sub  = 2'h0;
    word      = 32'h00000000;
    lane      = 8'h00;
    p         = 3'h0;
    s         = 2'h0;
    for (k = 0; k < NSRC; k = k + 1) begin
      word = prio_q[k/4];
      lane = word[8*(k%4) +: 8];
      // [R4] priority field
      p = lane[`IEPB_PRIO_LSB +: `IEPB_PRIO_W];
      // [R5] subpriority field
      s = lane[`IEPB_SUB_LSB +: `IEPB_SUB_W];
      // [R2] zero priority disables
      // [R9] qualify and compare
      if (flags_q[k] && enable_q[k] && p != 3'h0) begin
        // [R3] subpriority tie break; lower index wins full ties
        if (!best_req || p > best_prio || (p == best_prio && s > best_sub)) begin
          best_req  = 1'b1;
          best_vec  = k[4:0];
          best_prio = p;
          best_sub  = s;
        end
      end
    end
  end

  // Registered presentation to the core
  // [R9] presented request
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_core_req  <= 1'b0;
      o_core_vec  <= 5'h00;
      o_core_prio <= 3'h0;
      o_core_sub  <= 2'h0;
    end else begin
      o_core_req  <= best_req;
      o_core_vec  <= best_vec;
      o_core_prio <= best_prio;
      o_core_sub  <= best_sub;
    end
  end

  // Event detection: new winner, or access to a hole
  wire new_req  = best_req && (!last_req_q || best_vec != last_vec_q);
  wire bad_addr = (i_wr || i_rd) && !addr_ok;
  wire [`IEPB_EVT_W-1:0] evt_set;
  assign evt_set = {bad_addr, new_req};

  // Sticky status, set beats write-one-to-clear
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      evt_stat_q <= 2'h0;
      evt_mask_q <= 2'h0;
      last_vec_q <= 5'h00;
      last_req_q <= 1'b0;
    end else begin
      last_vec_q <= best_vec;
      last_req_q <= best_req;
      if (i_wr && i_addr == `IEPB_ADDR_EVT_STAT) begin
        evt_stat_q <= (evt_stat_q & ~i_wdata[`IEPB_EVT_W-1:0]) | evt_set;
      end else begin
        evt_stat_q <= evt_stat_q | evt_set;
      end
      if (i_wr && i_addr == `IEPB_ADDR_EVT_MASK) begin
        evt_mask_q <= i_wdata[`IEPB_EVT_W-1:0];
      end
    end
  end

  assign o_irq = |(evt_stat_q & evt_mask_q);

  // Read data, valid the cycle after the strobe only
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h00000000;
    if (hit_prio) begin
      rd_d = prio_q[prio_idx];
    end else begin
      case (i_addr)
        `IEPB_ADDR_FLAGS:    rd_d = flags_q;
        `IEPB_ADDR_ENABLE:   rd_d = enable_q;
        `IEPB_ADDR_EVT_STAT: rd_d = {30'h0, evt_stat_q};
        `IEPB_ADDR_EVT_MASK: rd_d = {30'h0, evt_mask_q};
        `IEPB_ADDR_PRESENT:  rd_d = {21'h0, o_core_req, o_core_prio, o_core_sub, o_core_vec};
        default:             rd_d = 32'h00000000;
      endcase
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      o_rdata <= rd_d;
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

endmodule // iepb_bank

// *** testbench/iepb_bank_asserts.sv ***
`timescale 1ns/10ps
// Port-level checks on the bank
module iepb_chk (
  input logic        i_ref_clk,
  input logic        i_rst_n,
  input logic [7:0]  i_addr,
  input logic [31:0] i_wdata,
  input logic        i_wr,
  input logic        i_rd,
  input logic [31:0] o_rdata,
  input logic [31:0] i_src_req,
  input logic        o_core_req,
  input logic [2:0]  o_core_prio
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  lane_zero_a: assert property ($past(i_rd) && $past(i_addr[7:4]) inside {1, 2}
    |-> (o_rdata & 32'hE0E0E0E0) == 0) else $error("lane top bits set");
  en_rw_a: assert property ($past(i_wr) && i_rd && i_addr == 8'h04 && $past(i_addr) == i_addr
    |=> o_rdata == $past(i_wdata, 2)) else $error("enable readback");
  prio_rw_a: assert property ($past(i_wr) && i_rd && i_addr == $past(i_addr)
    && i_addr[7:4] inside {1, 2} && i_addr[1:0] == 2'h0
    |=> o_rdata == ($past(i_wdata, 2) & 32'h1F1F1F1F))
    else $error("priority readback");
  prio_nz_a: assert property (o_core_req |-> o_core_prio != 0) else $error("zero prio");
  rst_zero_a: assert property ($rose(i_rst_n) |-> !o_core_req && o_rdata == 0)
    else $error("not clear after reset");
  flag_rd_a: assert property ($past(i_rd) && $past(i_addr) == 8'h00
    |-> (o_rdata & $past(i_src_req, 2)) == $past(i_src_req, 2)) else $error("flag lost");
  req_cause_a: assert property ($rose(o_core_req) |-> $past(i_src_req != 0 || i_wr, 2))
    else $error("request without cause");
  en_drop_a: assert property ($past(i_wr) && $past(i_addr) == 8'h04 && $past(i_wdata) == 0
    |=> !o_core_req) else $error("request while disabled");
endmodule // iepb_chk

// *** testbench/iepb_core_model.sv ***
`timescale 1ns/10ps
// Core input: takes the presented request each rising edge
module iepb_core_model (
  input  logic        i_clk,
  input  logic        i_rst_n,
  input  logic [10:0] i_req,
  output logic [10:0] o_seen
);
  // Core samples the lines once a cycle
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_seen <= 11'h000;
    else o_seen <= i_req;
  end
endmodule // iepb_core_model

// *** testbench/test_iepb_bank.sv ***
`timescale 1ns/10ps
module test_iepb_bank;
  logic        clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, i_src_req = 32'h0, rs = 32'h00011756, d, en, fl, pr [8];
  wire  [31:0] o_rdata;
  wire         o_core_req, o_irq;
  wire  [4:0]  vec;
  wire  [2:0]  pri;
  wire  [1:0]  sub;
  wire  [10:0] seen;
  int          err_count = 0, n_tests = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  iepb_bank uut (.i_ref_clk(clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_src_req(i_src_req), .o_core_req(o_core_req),
    .o_core_vec(vec), .o_core_prio(pri), .o_core_sub(sub), .o_irq(o_irq));
  iepb_core_model core (.i_clk(clk), .i_rst_n(i_rst_n), .i_req({o_core_req, vec, pri, sub}),
    .o_seen(seen));
  function automatic logic [31:0] rnd();
    rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
    return rs;
  endfunction
  // Reference arbiter: priority, then subpriority, then lowest index
  function automatic logic [31:0] win(logic [31:0] f);
    int b = -1, p, s, bp = 0, bs = 0;
    for (int i = 0; i < 32; i++) begin
      p = (pr[i / 4] >> (8 * (i % 4) + 2)) & 7;
      s = (pr[i / 4] >> (8 * (i % 4))) & 3;
      if (f[i] && en[i] && p > 0 && (b < 0 || p > bp || (p == bp && s > bs))) begin
        b = i; bp = p; bs = s;
      end
    end
    return b < 0 ? 32'h0 : {21'h0, 1'b1, 5'(b), 3'(bp), 2'(bs)};
  endfunction
  task chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task bus(input logic w, r, input logic [7:0] a, input logic [31:0] v);
    i_wr <= w; i_rd <= r; i_addr <= a; i_wdata <= v;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(0, 1, a, 0); i_rd <= 0;
    #1 chk("rdata", e, o_rdata);
    @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    bus(1, 0, a, v); i_wr <= 0;
    @(posedge clk);
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    i_rst_n <= 1;
    @(posedge clk);
    // Configuration must read clear after reset
    for (int j = 0; j < 9; j++) rd(j ? 8'(12 + 4 * j) : 8'h04, 32'h0);
    $display("reset test done");
    for (int k = 0; k < 6; k++) begin
      en = rnd();
      bus(1, 0, 8'h04, en);
      rd(8'h04, en);
      for (int j = 0; j < 8; j++) begin
        d = rnd(); pr[j] = d & 32'h1F1F1F1F;
        bus(1, 0, 8'(16 + 4 * j), d);
        rd(8'(16 + 4 * j), pr[j]);
      end
      wr(8'h00, 32'h0);
      fl = rnd(); i_src_req <= fl;
      @(posedge clk); i_src_req <= 32'h0;
      repeat (3) @(posedge clk);
      #1 chk("core", win(fl), {21'h0, seen});
      @(posedge clk);
      rd(8'h00, fl);
      d = win(fl);
      rd(8'h38, {21'h0, d[10], d[4:2], d[1:0], d[9:5]});
      $display("arbitration round %0d done", k);
    end
    wr(8'h04, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk("core", 32'h0, {21'h0, seen});
    @(posedge clk);
    rd(8'hFC, 32'h0);
    chk("irq", 0, o_irq);
    wr(8'h34, 32'h2);
    chk("irq", 1, o_irq);
    rd(8'h34, 32'h2);
    wr(8'h30, 32'h3);
    chk("irq", 0, o_irq);
    rd(8'h30, 32'h0);
    $display("interrupt test done");
    wrap_up();
  end
endmodule // test_iepb_bank
bind iepb_bank iepb_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_src_req(i_src_req),
  .o_core_req(o_core_req), .o_core_prio(o_core_prio));
